// File: hw/fzpc_pkg.sv
// shared constants for the fan zone and pin configuration register group
package fzpc_pkg;
  // data and structure sizes
  localparam int unsigned DATA_W       = 8;   // register width
  localparam int unsigned NUM_CHANNELS = 10;  // remote temperature channels
  localparam int unsigned NUM_PINS     = 4;   // fan drive pins

  // register addresses on the serial register port
  localparam logic [7:0] ADDR_HOTTEST   = 8'h78;  // hottest-sensor reading, read only
  localparam logic [7:0] ADDR_ZONE      = 8'h7d;  // fan 3 and fan 4 source select
  localparam logic [7:0] ADDR_COEF_HIGH = 8'h7e;  // coefficient choice bits 9..2
  localparam logic [7:0] ADDR_COEF_LOW  = 8'h7f;  // coefficient bits 1..0 and pin convert
  localparam logic [7:0] ADDR_PIN_SETUP = 8'h80;  // pin direction and polarity

  // values after power-on
  localparam logic [7:0] RST_ZONE      = 8'h00;
  localparam logic [7:0] RST_COEF_HIGH = 8'h00;
  localparam logic [7:0] RST_COEF_LOW  = 8'h00;
  localparam logic [7:0] RST_PIN_SETUP = 8'h00;
  localparam logic [7:0] RST_HOTTEST   = 8'h00;
  localparam logic [7:0] RST_RDATA     = 8'h00;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;  // answer to an unknown address

  // field positions in the zone register
  localparam int unsigned THIRD_SRC_MSB  = 7;
  localparam int unsigned THIRD_SRC_LSB  = 4;
  localparam int unsigned FOURTH_SRC_MSB = 3;
  localparam int unsigned FOURTH_SRC_LSB = 0;

  // field positions in the low coefficient register
  localparam int unsigned COEF_LOW_MSB = 7;  // coefficient choice bit 1
  localparam int unsigned COEF_LOW_LSB = 6;  // coefficient choice bit 0
  localparam logic [7:0]  COEF_LOW_WMASK = 8'hdf;  // bit 5 is not implemented
  localparam int unsigned CONVERT_POS [4] = '{3, 2, 1, 0};  // pins 1..4

  // field positions in the pin setup register, pins 1..4
  localparam int unsigned DIR_POS [4] = '{7, 5, 3, 1};
  localparam int unsigned POL_POS [4] = '{6, 4, 2, 0};

  // source select codes
  localparam logic [3:0] ZONE_HOTTEST       = 4'h0;  // hottest-sensor reading
  localparam logic [3:0] ZONE_FIRST_CHANNEL = 4'h1;  // channel 1
  localparam logic [3:0] ZONE_LAST_CHANNEL  = 4'ha;  // channel 10
endpackage

// File: hw/fzpc_zone_mux.sv
`timescale 1ns/1ps
`default_nettype none
// picks the temperature that governs one fan from its 4-bit source code
module fzpc_zone_mux (
  input  wire logic                  clock_i,         // system clock
  input  wire logic                  rst_n_i,         // async reset, active low
  input  wire logic [3:0]            source_sel_i,    // source select code
  input  wire logic [7:0]            hottest_i,       // hottest-sensor reading
  input  wire logic [9:0][7:0]       channel_temp_i,  // channels 10..1
  output logic      [7:0]            fan_temp_o       // selected temperature
);
  // module state
  typedef struct packed {
    logic [7:0] temp;  // registered selection
  } fzpc_mux_state_t;

  fzpc_mux_state_t st;       // current state
  fzpc_mux_state_t next_st;  // next state

  // selection: codes 1..10 pick a channel, all others the hottest reading
  always_comb begin
    next_st = st;
    if (source_sel_i >= fzpc_pkg::ZONE_FIRST_CHANNEL &&
        source_sel_i <= fzpc_pkg::ZONE_LAST_CHANNEL) begin
      next_st.temp = channel_temp_i[source_sel_i - fzpc_pkg::ZONE_FIRST_CHANNEL];
    end else begin
      next_st.temp = hottest_i;
    end
  end

  // state register
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '{temp: fzpc_pkg::RST_HOTTEST};
    end else begin
      st <= next_st;
    end
  end

  assign fan_temp_o = st.temp;

  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  a_zone_hot_default: assert property (
    (source_sel_i == 4'h0 || source_sel_i > 4'ha) |=> fan_temp_o == $past(hottest_i))
    else $error("hottest reading not selected");
  a_zone_channel_pick: assert property (
    (source_sel_i >= 4'h1 && source_sel_i <= 4'ha)
      |=> fan_temp_o == $past(channel_temp_i[source_sel_i - 4'h1]))
    else $error("wrong channel selected");
endmodule
`default_nettype wire

// File: hw/fzpc_pin_cell.sv
`timescale 1ns/1ps
`default_nettype none
// one fan drive pin that may be turned into a general-purpose pin
module fzpc_pin_cell (
  input  wire logic clock_i,      // system clock
  input  wire logic rst_n_i,      // async reset, active low
  input  wire logic convert_i,    // pin is a general-purpose pin
  input  wire logic direction_i,  // 1 output, 0 input
  input  wire logic polarity_i,   // 1 active high, 0 active low
  input  wire logic out_data_i,   // lsb of the minimum duty-cycle register
  input  wire logic fan_wave_i,   // fan drive waveform
  input  wire logic pin_i,        // level seen on the pin
  output logic      pin_o,        // level driven on the pin
  output logic      pin_oe_o,     // high while the pin is driven
  output logic      asserted_o    // input asserted, after polarity
);
  // module state
  typedef struct packed {
    logic sync_a;    // first synchroniser stage
    logic sync_b;    // second synchroniser stage
    logic pin_out;   // driven level
    logic pin_oe;    // drive enable
    logic asserted;  // sensed input state
  } fzpc_pin_state_t;

  fzpc_pin_state_t st;       // current state
  fzpc_pin_state_t next_st;  // next state

  // pin mode selection
  always_comb begin
    next_st        = st;
    next_st.sync_a = pin_i;
    next_st.sync_b = st.sync_a;
    if (!convert_i) begin
      // normal fan drive
      next_st.pin_out  = fan_wave_i;
      next_st.pin_oe   = 1'b1;
      next_st.asserted = 1'b0;
    end else if (direction_i) begin
      // output: asserted data shown at the chosen polarity
      next_st.pin_out  = polarity_i ? out_data_i : ~out_data_i;
      next_st.pin_oe   = 1'b1;
      next_st.asserted = 1'b0;
    end else begin
      // input: released, sensed through the synchroniser
      next_st.pin_out  = 1'b0;
      next_st.pin_oe   = 1'b0;
      next_st.asserted = st.sync_b ~^ polarity_i;
    end
  end

  // state register
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pin_o      = st.pin_out;
  assign pin_oe_o   = st.pin_oe;
  assign asserted_o = st.asserted;

  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  a_pin_fan_drive: assert property (
    !convert_i |=> pin_oe_o && pin_o == $past(fan_wave_i))
    else $error("unconverted pin lost fan waveform");
  a_pin_output_level: assert property (
    (convert_i && direction_i)
      |=> pin_oe_o && pin_o == ($past(out_data_i) ~^ $past(polarity_i)))
    else $error("wrong output level on pin");
  a_pin_input_sense: assert property (
    (convert_i && !direction_i)
      |=> !pin_oe_o && asserted_o == ($past(pin_i, 3) ~^ $past(polarity_i)))
    else $error("input pin sensed wrongly");
endmodule
`default_nettype wire

// File: hw/fzpc_regs.sv
`timescale 1ns/1ps
`default_nettype none
module fzpc_regs (
  input  wire logic            clock_i,            // system clock, 100 MHz
  input  wire logic            rst_n_i,            // async power-on reset, active low
  // register port from the serial interface engine
  input  wire logic [7:0]      reg_addr_i,         // register address
  input  wire logic            reg_wr_i,           // write strobe, one cycle
  input  wire logic [7:0]      reg_wdata_i,        // write data
  input  wire logic            reg_rd_i,           // read strobe, one cycle
  output logic      [7:0]      reg_rdata_o,        // read data, next cycle
  // temperature channels 10..1 from the decoder
  input  wire logic [9:0][7:0] channel_temp_i,     // channel k at index k-1
  output logic      [7:0]      hottest_temp_o,     // hottest-sensor reading
  output logic      [7:0]      third_fan_temp_o,   // temperature governing fan 3
  output logic      [7:0]      fourth_fan_temp_o,  // temperature governing fan 4
  output logic      [9:0]      coef_optional_o,    // 1 uses optional coefficients
  // fan drive pins 1..4 at indices 0..3
  input  wire logic [3:0]      fan_wave_i,         // fan drive waveforms
  input  wire logic [3:0]      min_duty_lsb_i,     // minimum duty-cycle lsbs
  input  wire logic [3:0]      pin_i,              // pin levels
  output logic      [3:0]      pin_o,              // driven levels
  output logic      [3:0]      pin_oe_o,           // drive enables
  output logic      [3:0]      pin_asserted_o      // sensed input states
);
  // all register state
  typedef struct packed {
    logic [7:0] zone;       // fan 3 and fan 4 source select
    logic [7:0] coef_high;  // coefficient choice bits 9..2
    logic [7:0] coef_low;   // choice bits 1..0, reserved, pin converts
    logic [7:0] pin_setup;  // direction and polarity
    logic [7:0] hottest;    // maximum of all channels
    logic [7:0] rdata;      // read answer
    logic       written;    // any write since reset
  } fzpc_regs_state_t;

  fzpc_regs_state_t st;       // current state
  fzpc_regs_state_t next_st;  // next state

  logic [7:0] max_temp;            // running maximum over the channels
  logic       hot_ge_all;          // hottest reading not below any channel
  logic       hot_hit;             // hottest reading equals some channel
  logic [3:0] third_fan_source;    // fan 3 source code
  logic [3:0] fourth_fan_source;   // fan 4 source code
  logic [3:0] pin_convert;         // per pin convert bit
  logic [3:0] pin_direction;       // per pin direction
  logic [3:0] pin_polarity;        // per pin polarity

  // source fields
  assign third_fan_source  = st.zone[fzpc_pkg::THIRD_SRC_MSB:fzpc_pkg::THIRD_SRC_LSB];
  assign fourth_fan_source = st.zone[fzpc_pkg::FOURTH_SRC_MSB:fzpc_pkg::FOURTH_SRC_LSB];

  // hottest-sensor reading: maximum over all channels
  always_comb begin
    max_temp = channel_temp_i[0];
    for (int i = 1; i < fzpc_pkg::NUM_CHANNELS; i++) begin
      if (channel_temp_i[i] > max_temp) begin
        max_temp = channel_temp_i[i];
      end
    end
  end

  // register writes, the read answer and the hottest reading
  always_comb begin
    next_st         = st;
    next_st.hottest = max_temp;
    if (reg_wr_i) begin
      next_st.written = 1'b1;
      unique case (reg_addr_i)
        fzpc_pkg::ADDR_ZONE: begin
          next_st.zone = reg_wdata_i;
        end
        fzpc_pkg::ADDR_COEF_HIGH: begin
          next_st.coef_high = reg_wdata_i;
        end
        fzpc_pkg::ADDR_COEF_LOW: begin
          // unimplemented bit is dropped; reserved bit is stored as written
          next_st.coef_low = reg_wdata_i & fzpc_pkg::COEF_LOW_WMASK;
        end
        fzpc_pkg::ADDR_PIN_SETUP: begin
          next_st.pin_setup = reg_wdata_i;
        end
        default: begin
          // hottest register and unknown addresses ignore writes
        end
      endcase
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        fzpc_pkg::ADDR_HOTTEST: begin
          next_st.rdata = st.hottest;
        end
        fzpc_pkg::ADDR_ZONE: begin
          next_st.rdata = st.zone;
        end
        fzpc_pkg::ADDR_COEF_HIGH: begin
          next_st.rdata = st.coef_high;
        end
        fzpc_pkg::ADDR_COEF_LOW: begin
          next_st.rdata = st.coef_low;
        end
        fzpc_pkg::ADDR_PIN_SETUP: begin
          next_st.rdata = st.pin_setup;
        end
        default: begin
          next_st.rdata = fzpc_pkg::UNMAPPED_DATA;
        end
      endcase
    end
  end

  // state register, cleared at power-on
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '{zone:      fzpc_pkg::RST_ZONE,
              coef_high: fzpc_pkg::RST_COEF_HIGH,
              coef_low:  fzpc_pkg::RST_COEF_LOW,
              pin_setup: fzpc_pkg::RST_PIN_SETUP,
              hottest:   fzpc_pkg::RST_HOTTEST,
              rdata:     fzpc_pkg::RST_RDATA,
              written:   1'b0};
    end else begin
      st <= next_st;
    end
  end

  // register outputs
  assign reg_rdata_o     = st.rdata;
  assign hottest_temp_o  = st.hottest;
  // bit set: that channel converts with optional gain and offset
  assign coef_optional_o = {st.coef_high,
                            st.coef_low[fzpc_pkg::COEF_LOW_MSB:fzpc_pkg::COEF_LOW_LSB]};

  // fan 3 source selection
  fzpc_zone_mux u_third_fan_mux (
    .clock_i        (clock_i),
    .rst_n_i        (rst_n_i),
    .source_sel_i   (third_fan_source),
    .hottest_i      (st.hottest),
    .channel_temp_i (channel_temp_i),
    .fan_temp_o     (third_fan_temp_o)
  );

  // fan 4 source selection, same code table
  fzpc_zone_mux u_fourth_fan_mux (
    .clock_i        (clock_i),
    .rst_n_i        (rst_n_i),
    .source_sel_i   (fourth_fan_source),
    .hottest_i      (st.hottest),
    .channel_temp_i (channel_temp_i),
    .fan_temp_o     (fourth_fan_temp_o)
  );

  // per pin field extraction and pin cells
  for (genvar k = 0; k < fzpc_pkg::NUM_PINS; k++) begin : g_pin
    assign pin_convert[k]   = st.coef_low[fzpc_pkg::CONVERT_POS[k]];
    assign pin_direction[k] = st.pin_setup[fzpc_pkg::DIR_POS[k]];
    assign pin_polarity[k]  = st.pin_setup[fzpc_pkg::POL_POS[k]];

    fzpc_pin_cell u_pin (
      .clock_i     (clock_i),
      .rst_n_i     (rst_n_i),
      .convert_i   (pin_convert[k]),
      .direction_i (pin_direction[k]),
      .polarity_i  (pin_polarity[k]),
      .out_data_i  (min_duty_lsb_i[k]),
      .fan_wave_i  (fan_wave_i[k]),
      .pin_i       (pin_i[k]),
      .pin_o       (pin_o[k]),
      .pin_oe_o    (pin_oe_o[k]),
      .asserted_o  (pin_asserted_o[k])
    );
  end

  // helpers for the maximum check: the running maximum must not lie below
  // any channel and must be one of them, so a broken loop is caught
  always_comb begin
    hot_ge_all = 1'b1;
    hot_hit    = 1'b0;
    for (int i = 0; i < fzpc_pkg::NUM_CHANNELS; i++) begin
      // a channel above the maximum
      if (channel_temp_i[i] > max_temp) begin
        hot_ge_all = 1'b0;
      end
      // a channel that equals the maximum
      if (channel_temp_i[i] == max_temp) begin
        hot_hit = 1'b1;
      end
    end
  end

  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  // write to the zone register
  sequence s_zone_write;
    reg_wr_i && reg_addr_i == 8'h7d;
  endsequence

  // zone write followed by a quiet cycle on the zone register
  sequence s_zone_settle;
    s_zone_write ##1 !(reg_wr_i && reg_addr_i == 8'h7d);
  endsequence

  // write to the low coefficient register
  sequence s_coef_low_write;
    reg_wr_i && reg_addr_i == 8'h7f;
  endsequence

  // read of the hottest register
  sequence s_hottest_read;
    reg_rd_i && reg_addr_i == fzpc_pkg::ADDR_HOTTEST;
  endsequence

  // write to the pin setup register
  sequence s_pin_setup_write;
    reg_wr_i && reg_addr_i == fzpc_pkg::ADDR_PIN_SETUP;
  endsequence

  a_zone_third_field: assert property (
    s_zone_write |=> third_fan_source == $past(reg_wdata_i[7:4]))
    else $error("fan 3 source field not written");
  a_zone_fourth_field: assert property (
    s_zone_write |=> fourth_fan_source == $past(reg_wdata_i[3:0]))
    else $error("fan 4 source field not written");
  a_zone_hot_path: assert property (
    (s_zone_settle ##0 third_fan_source == 4'h0) |=> third_fan_temp_o == $past(st.hottest))
    else $error("fan 3 not on hottest reading");
  a_coef_high_write: assert property (
    (reg_wr_i && reg_addr_i == 8'h7e) |=> coef_optional_o[9:2] == $past(reg_wdata_i))
    else $error("high coefficient bits not written");
  a_coef_low_write: assert property (
    s_coef_low_write |=> coef_optional_o[1:0] == $past(reg_wdata_i[7:6])
      && pin_convert == {$past(reg_wdata_i[0]), $past(reg_wdata_i[1]),
                         $past(reg_wdata_i[2]), $past(reg_wdata_i[3])})
    else $error("low coefficient or convert bits not written");
  // hottest reading: one cycle behind the channels, never below one of them
  // and equal to one of them
  a_hottest_bound: assert property (
    1'b1 |=> hottest_temp_o == $past(max_temp) && $past(hot_ge_all) && $past(hot_hit))
    else $error("hottest reading wrong");
  a_hottest_read: assert property (
    s_hottest_read |=> reg_rdata_o == $past(hottest_temp_o))
    else $error("hottest reading read back wrong");
  // a write to the read-only address leaves the configuration alone
  a_hottest_read_only: assert property (
    (reg_wr_i && reg_addr_i == fzpc_pkg::ADDR_HOTTEST)
      |=> $stable(st.zone) && $stable(st.coef_high)
      && $stable(st.coef_low) && $stable(st.pin_setup))
    else $error("write to read-only address changed a register");
  a_power_on_clear: assert property (
    !st.written |-> st.zone == 8'h00 && st.coef_high == 8'h00
      && st.coef_low == 8'h00 && st.pin_setup == 8'h00)
    else $error("configuration not clear after reset");
  a_pin_setup_read: assert property (
    (reg_rd_i && reg_addr_i == 8'h80) |=> reg_rdata_o == $past(st.pin_setup))
    else $error("pin setup read back wrong");
  a_pin_setup_write: assert property (
    s_pin_setup_write
      |=> pin_direction == {$past(reg_wdata_i[1]), $past(reg_wdata_i[3]),
                            $past(reg_wdata_i[5]), $past(reg_wdata_i[7])}
      && pin_polarity == {$past(reg_wdata_i[0]), $past(reg_wdata_i[2]),
                          $past(reg_wdata_i[4]), $past(reg_wdata_i[6])})
    else $error("pin direction or polarity not written");

  // read answers of the other configuration registers
  a_zone_read: assert property (
    (reg_rd_i && reg_addr_i == fzpc_pkg::ADDR_ZONE)
      |=> reg_rdata_o == $past(st.zone))
    else $error("zone register read back wrong");
  a_coef_high_read: assert property (
    (reg_rd_i && reg_addr_i == fzpc_pkg::ADDR_COEF_HIGH)
      |=> reg_rdata_o == $past(st.coef_high))
    else $error("high coefficient register read back wrong");
  a_coef_low_read: assert property (
    (reg_rd_i && reg_addr_i == fzpc_pkg::ADDR_COEF_LOW)
      |=> reg_rdata_o == $past(st.coef_low))
    else $error("low coefficient register read back wrong");
  // the unimplemented bit of the low coefficient register stays clear
  a_coef_low_unused: assert property (
    s_coef_low_write |=> st.coef_low[5] == 1'b0)
    else $error("unimplemented coefficient bit stored");

  // an undefined fan 4 code falls back to the hottest reading
  a_zone_undefined_code: assert property (
    (s_zone_settle ##0 fourth_fan_source > 4'ha)
      |=> fourth_fan_temp_o == $past(st.hottest))
    else $error("fan 4 not on hottest reading for undefined code");
endmodule
`default_nettype wire

// File: verif/fzpc_testbench.sv
`timescale 1ns/1ps
`default_nettype none
// self-checking bench for the fan zone and pin configuration register group
module testbench;
  logic            clock_i;            // system clock
  logic            rst_n_i;            // reset, active low
  logic [7:0]      reg_addr_i;         // register address
  logic            reg_wr_i;           // write strobe
  logic [7:0]      reg_wdata_i;        // write data
  logic            reg_rd_i;           // read strobe
  logic [7:0]      reg_rdata_o;        // read answer
  logic [9:0][7:0] channel_temp_i;     // channel temperatures
  logic [7:0]      hottest_temp_o;     // hottest reading
  logic [7:0]      third_fan_temp_o;   // fan 3 temperature
  logic [7:0]      fourth_fan_temp_o;  // fan 4 temperature
  logic [9:0]      coef_optional_o;    // coefficient choices
  logic [3:0]      fan_wave_i;         // fan drive waveforms
  logic [3:0]      min_duty_lsb_i;     // output data bits
  logic [3:0]      pin_i;              // pin levels
  logic [3:0]      pin_o;              // driven levels
  logic [3:0]      pin_oe_o;           // drive enables
  logic [3:0]      pin_asserted_o;     // sensed input states
  int              errors;             // mismatches seen
  int              check_count;        // comparisons made
  logic [31:0]     seed;               // xorshift state

  fzpc_regs u_fzpc_regs (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .channel_temp_i(channel_temp_i), .hottest_temp_o(hottest_temp_o),
    .third_fan_temp_o(third_fan_temp_o), .fourth_fan_temp_o(fourth_fan_temp_o),
    .coef_optional_o(coef_optional_o), .fan_wave_i(fan_wave_i),
    .min_duty_lsb_i(min_duty_lsb_i), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
    .pin_asserted_o(pin_asserted_o)
  );

  // free-running 100 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  // xorshift source of repeatable random values
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // hottest channel, compared unsigned
  function automatic logic [7:0] exp_max(input logic [9:0][7:0] ch);
    logic [7:0] m;
    m = 8'h00;
    for (int k = 0; k < 10; k++) begin
      if (ch[k] > m) m = ch[k];
    end
    return m;
  endfunction

  // temperature a source code selects; undefined codes fall back to hottest
  function automatic logic [7:0] exp_temp(input logic [3:0] code);
    if (code >= 4'h1 && code <= 4'ha) return channel_temp_i[code - 4'h1];
    return exp_max(channel_temp_i);
  endfunction

  // expected {enable, level, asserted} of one pin
  function automatic logic [2:0] exp_pin(input logic conv, dir, pol, dat, wave, pin);
    if (!conv) return {1'b1, wave, 1'b0};
    if (dir) return {1'b1, pol ? dat : ~dat, 1'b0};
    return {1'b0, 1'b0, pin ~^ pol};
  endfunction

  // one comparison, reported at once on a difference
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // wait n edges, then step just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  // one-cycle write strobe
  task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
    tick(1);
    reg_addr_i = addr;
    reg_wdata_i = data;
    reg_wr_i = 1'b1;
    tick(1);
    reg_wr_i = 1'b0;
  endtask

  // one-cycle read strobe, answer taken the cycle after
  task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
    tick(1);
    reg_addr_i = addr;
    reg_rd_i = 1'b1;
    tick(1);
    reg_rd_i = 1'b0;
    data = reg_rdata_o;
  endtask

  // verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // the four configuration registers read back zero after a reset
  task automatic check_cleared();
    logic [7:0] d;
    logic [7:0] addrs [4];
    addrs = '{fzpc_pkg::ADDR_ZONE, fzpc_pkg::ADDR_COEF_HIGH, fzpc_pkg::ADDR_COEF_LOW,
              fzpc_pkg::ADDR_PIN_SETUP};
    foreach (addrs[i]) begin
      reg_read(addrs[i], d);
      check(16'(d), 16'h0000, "reset value");
    end
    check(16'(coef_optional_o), 16'h0000, "coef after reset");
  endtask

  // guard against a hang
  initial begin
    repeat (20000) @(posedge clock_i);
    errors++;
    $display("mismatch at %0t: run did not finish", $time);
    test_done();
  end

  // main sequence
  initial begin
    logic [7:0] d;
    logic [7:0] zone;
    logic [7:0] r7e;
    logic [7:0] r7f;
    logic [7:0] r80;
    logic [2:0] pe;  // expected pin view
    logic [2:0] ps;  // seen pin view
    errors = 0;
    check_count = 0;
    seed = 32'h12df;
    rst_n_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wr_i = 1'b0;
    reg_wdata_i = 8'h00;
    reg_rd_i = 1'b0;
    channel_temp_i = '0;
    fan_wave_i = 4'h0;
    min_duty_lsb_i = 4'h0;
    pin_i = 4'h0;
    tick(20);
    rst_n_i = 1'b1;
    check_cleared();
    reg_write(8'h55, 8'ha5);
    reg_read(8'h55, d);
    check(16'(d), 16'(fzpc_pkg::UNMAPPED_DATA), "unmapped read");
    $display("test reset_values done");
    // every source code on both fans, then random codes
    for (int n = 0; n < 24; n++) begin
      zone = (n < 16) ? {4'(n), 4'(15 - n)} : 8'(rnd());
      for (int k = 0; k < 10; k++) channel_temp_i[k] = 8'(rnd());
      reg_write(fzpc_pkg::ADDR_ZONE, zone);
      tick(3);
      check(16'(hottest_temp_o), 16'(exp_max(channel_temp_i)), "hottest");
      check(16'(third_fan_temp_o), 16'(exp_temp(zone[7:4])), "fan3");
      check(16'(fourth_fan_temp_o), 16'(exp_temp(zone[3:0])), "fan4");
      reg_read(fzpc_pkg::ADDR_ZONE, d);
      check(16'(d), 16'(zone), "zone readback");
      reg_write(fzpc_pkg::ADDR_HOTTEST, 8'(rnd()));
      reg_read(fzpc_pkg::ADDR_HOTTEST, d);
      check(16'(d), 16'(exp_max(channel_temp_i)), "hottest read only");
    end
    $display("test zone_select done");
    // random coefficient choices and pin modes
    for (int n = 0; n < 32; n++) begin
      r7e = 8'(rnd());
      r7f = 8'(rnd()) & 8'hef;
      r80 = 8'(rnd());
      fan_wave_i = 4'(rnd());
      min_duty_lsb_i = 4'(rnd());
      pin_i = 4'(rnd());
      reg_write(fzpc_pkg::ADDR_COEF_HIGH, r7e);
      reg_write(fzpc_pkg::ADDR_COEF_LOW, r7f);
      reg_write(fzpc_pkg::ADDR_PIN_SETUP, r80);
      tick(4);
      check(16'(coef_optional_o), 16'({r7e, r7f[7:6]}), "coef choice");
      for (int p = 0; p < 4; p++) begin
        pe = exp_pin(r7f[fzpc_pkg::CONVERT_POS[p]], r80[fzpc_pkg::DIR_POS[p]],
                     r80[fzpc_pkg::POL_POS[p]], min_duty_lsb_i[p], fan_wave_i[p], pin_i[p]);
        ps = {pin_oe_o[p], pin_o[p], pin_asserted_o[p]};
        check(16'(ps), 16'(pe), "pin");
      end
      reg_read(fzpc_pkg::ADDR_COEF_HIGH, d);
      check(16'(d), 16'(r7e), "coef high readback");
      reg_read(fzpc_pkg::ADDR_COEF_LOW, d);
      check(16'(d), 16'(r7f & fzpc_pkg::COEF_LOW_WMASK), "coef low readback");
      reg_read(fzpc_pkg::ADDR_PIN_SETUP, d);
      check(16'(d), 16'(r80), "pin setup readback");
    end
    $display("test pin_modes done");
    // second reset in mid-run
    tick(1);
    rst_n_i = 1'b0;
    tick(3);
    rst_n_i = 1'b1;
    check_cleared();
    $display("test second_reset done");
    test_done();
  end
endmodule
`default_nettype wire
